// [pkg/dcc_pkg.sv]
// Constants, field layout and shared helpers of the DMA CRC and checksum engine.
`default_nettype none
package dcc_pkg;
  localparam logic [7:0] DCC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] DCC_OFS_SEED_RESULT = 8'h10;
  localparam logic [7:0] DCC_OFS_FEEDBACK_MASK = 8'h20;
  localparam logic [1:0] DCC_ALIAS_WRITE = 2'h0;
  localparam logic [1:0] DCC_ALIAS_CLEAR = 2'h1;
  localparam logic [1:0] DCC_ALIAS_SET = 2'h2;
  localparam logic [1:0] DCC_ALIAS_INVERT = 2'h3;
  localparam logic [1:0] DCC_SEL_CONTROL = 2'h0;
  localparam logic [1:0] DCC_SEL_SEED = 2'h1;
  localparam logic [1:0] DCC_SEL_MASK = 2'h2;
  localparam logic [1:0] DCC_SEL_NONE = 2'h3;
  localparam int DCC_BIT_BYTE_ORDER = 28;
  localparam int DCC_BIT_WRITE_REORDER = 27;
  localparam int DCC_BIT_REFLECT = 24;
  localparam int DCC_BIT_POLY_LENGTH_MINUS_ONE = 8;
  localparam int DCC_BIT_ENABLE = 7;
  localparam int DCC_BIT_APPEND = 6;
  localparam int DCC_BIT_ALGORITHM = 5;
  localparam int DCC_BIT_CHANNEL = 0;
  localparam logic [31:0] DCC_CONTROL_WMASK = 32'h3900_1FE7;
  localparam logic [31:0] DCC_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] DCC_SEED_RESET = 32'h0000_0000;
  localparam logic [31:0] DCC_MASK_RESET = 32'h0000_0000;
  localparam logic [1:0] DCC_BYTE_ORDER_SELECT_KEEP = 2'h0;
  localparam logic [1:0] DCC_BYTE_ORDER_SELECT_WORD_REV = 2'h1;
  localparam logic [1:0] DCC_BYTE_ORDER_SELECT_HALF_SWAP = 2'h2;
  localparam logic [1:0] DCC_BYTE_ORDER_SELECT_HALF_REV = 2'h3;

  // Reorders the bytes of one data word.
  function automatic logic [31:0] dcc_reorder(input logic [1:0] order, input logic [31:0] d);
    case (order)
      DCC_BYTE_ORDER_SELECT_WORD_REV: dcc_reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
      DCC_BYTE_ORDER_SELECT_HALF_SWAP: dcc_reorder = {d[15:0], d[31:16]};
      DCC_BYTE_ORDER_SELECT_HALF_REV: dcc_reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: dcc_reorder = d;
    endcase
  endfunction

  // Ones in every bit position below the polynomial length.
  function automatic logic [31:0] dcc_len_mask(input logic [4:0] poly_length_minus_one);
    dcc_len_mask = 32'hFFFF_FFFF >> (5'd31 - poly_length_minus_one);
  endfunction
endpackage
`default_nettype wire

// [pkg/dcc_step_if.sv]
// Signals between the register side of the engine and its per-element step logic.
`timescale 1ns/1ps
`default_nettype none
interface dcc_step_if;
  logic [31:0] state;
  logic [31:0] data;
  logic [2:0] nbytes;
  logic [31:0] feedback;
  logic [4:0] poly_length_minus_one;
  logic reflect;
  logic ip_mode;
  logic [31:0] next_state;
  modport core (input state, data, nbytes, feedback, poly_length_minus_one, reflect, ip_mode, output next_state);
  modport user (output state, data, nbytes, feedback, poly_length_minus_one, reflect, ip_mode, input next_state);
endinterface
`default_nettype wire

// [hdl/dcc_crc_step.sv]
// Combinational next value of the CRC or checksum for one transferred element.
`timescale 1ns/1ps
`default_nettype none
module dcc_crc_step (
  dcc_step_if.core s
);
  logic [31:0] lfsr;
  logic [31:0] len_mask;
  logic [15:0] acc;
  logic [15:0] unit;
  logic [16:0] tmp;
  logic fb;
  logic din;

  // ---------------------------------------------------------------
  // LFSR and checksum update.
  // ---------------------------------------------------------------
  always_comb begin
    len_mask = dcc_pkg::dcc_len_mask(s.poly_length_minus_one);
    lfsr = s.state & len_mask;
    acc = s.state[15:0];
    unit = 16'h0000;
    tmp = 17'h0_0000;
    fb = 1'b0;
    din = 1'b0;
    for (int b = 0; b < 32; b++) begin
      if (b < 8 * int'(s.nbytes)) begin
        if (s.reflect) begin
          din = s.data[(b / 8) * 8 + (b % 8)];
          fb = lfsr[0] ^ din;
          lfsr = ((lfsr >> 1) ^ (s.feedback & {32{fb}})) & len_mask;
        end else begin
          din = s.data[(b / 8) * 8 + 7 - (b % 8)];
          fb = lfsr[s.poly_length_minus_one] ^ din;
          lfsr = ((lfsr << 1) ^ (s.feedback & {32{fb}})) & len_mask;
        end
      end
    end
    for (int h = 0; h < 2; h++) begin
      if (h == 0 || s.nbytes == 3'd4) begin
        unit = s.data[16 * h +: 16];
        if (s.nbytes == 3'd1) begin
          unit[15:8] = 8'h00;
        end
        if (s.reflect) begin
          unit = {<<{unit}};
        end
        tmp = {1'b0, acc} + {1'b0, unit};
        acc = tmp[15:0] + {15'h0000, tmp[16]};
      end
    end
    s.next_state = s.ip_mode ? {16'h0000, acc} : lfsr;
  end
endmodule // dcc_crc_step
`default_nettype wire

// [hdl/dcc_crc_engine.sv]
// Top of the DMA CRC and checksum engine: registers, data path and checks.
`timescale 1ns/1ps
`default_nettype none
module dcc_crc_engine (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_xfer_valid,
  input wire logic [2:0] i_xfer_chan,
  input wire logic [1:0] i_xfer_size,
  input wire logic [31:0] i_xfer_data,
  input wire logic i_block_done,
  output logic o_dst_write,
  output logic [31:0] o_dst_data,
  output logic o_dst_to_start
);
  logic [31:0] ctrl;
  logic [31:0] state;
  logic [31:0] feedback;
  logic [1:0] sel;
  logic [1:0] alias_op;
  logic [31:0] len_mask;
  logic [31:0] rd_value;
  logic [31:0] next_ctrl;
  logic [31:0] next_seed;
  logic [31:0] reordered;
  logic [2:0] nbytes;
  logic ip_mode;
  logic engaged;
  logic append;
  logic write_reorder;
  logic seed_wr;

  dcc_step_if step ();

  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  function automatic logic [1:0] dcc_decode(input logic [7:0] a);
    case ({a[7:4], 4'h0})
      dcc_pkg::DCC_OFS_CONTROL: dcc_decode = dcc_pkg::DCC_SEL_CONTROL;
      dcc_pkg::DCC_OFS_SEED_RESULT: dcc_decode = dcc_pkg::DCC_SEL_SEED;
      dcc_pkg::DCC_OFS_FEEDBACK_MASK: dcc_decode = dcc_pkg::DCC_SEL_MASK;
      default: dcc_decode = dcc_pkg::DCC_SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] dcc_alias(input logic [1:0] op, input logic [31:0] cur,
                                            input logic [31:0] wd);
    case (op)
      dcc_pkg::DCC_ALIAS_CLEAR: dcc_alias = cur & ~wd;
      dcc_pkg::DCC_ALIAS_SET: dcc_alias = cur | wd;
      dcc_pkg::DCC_ALIAS_INVERT: dcc_alias = cur ^ wd;
      default: dcc_alias = wd;
    endcase
  endfunction

  function automatic logic [2:0] dcc_size_bytes(input logic [1:0] size);
    case (size)
      2'h0: dcc_size_bytes = 3'd1;
      2'h1: dcc_size_bytes = 3'd2;
      default: dcc_size_bytes = 3'd4;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Decode and field views.
  // ---------------------------------------------------------------
  always_comb begin
    sel = dcc_decode(i_addr);
    alias_op = i_addr[3:2];
    ip_mode = ctrl[dcc_pkg::DCC_BIT_ALGORITHM];
    append = ctrl[dcc_pkg::DCC_BIT_APPEND];
    write_reorder = ctrl[dcc_pkg::DCC_BIT_WRITE_REORDER];
    engaged = ctrl[dcc_pkg::DCC_BIT_ENABLE]
      && (i_xfer_chan == ctrl[dcc_pkg::DCC_BIT_CHANNEL +: 3]);
    len_mask = dcc_pkg::dcc_len_mask(ctrl[dcc_pkg::DCC_BIT_POLY_LENGTH_MINUS_ONE +: 5]);
    if (ip_mode) begin
      rd_value = {16'h0000, ~state[15:0]};
    end else begin
      rd_value = state & len_mask;
    end
    reordered = dcc_pkg::dcc_reorder(ctrl[dcc_pkg::DCC_BIT_BYTE_ORDER +: 2], i_xfer_data);
    nbytes = dcc_size_bytes(i_xfer_size);
    seed_wr = i_wr && (sel == dcc_pkg::DCC_SEL_SEED);
    next_ctrl = dcc_alias(alias_op, ctrl, i_wdata) & dcc_pkg::DCC_CONTROL_WMASK;
    if (next_ctrl[dcc_pkg::DCC_BIT_WRITE_REORDER]) begin
      next_ctrl[dcc_pkg::DCC_BIT_APPEND] = 1'b0;
    end
    next_seed = dcc_alias(alias_op, rd_value, i_wdata);
  end

  // ---------------------------------------------------------------
  // Step logic.
  // ---------------------------------------------------------------
  assign step.state = state;
  assign step.data = reordered;
  assign step.nbytes = nbytes;
  assign step.feedback = feedback;
  assign step.poly_length_minus_one = ctrl[dcc_pkg::DCC_BIT_POLY_LENGTH_MINUS_ONE +: 5];
  assign step.reflect = ctrl[dcc_pkg::DCC_BIT_REFLECT];
  assign step.ip_mode = ip_mode;

  dcc_crc_step u_step (
    .s(step.core)
  );

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl <= dcc_pkg::DCC_CONTROL_RESET;
    end else if (i_wr && sel == dcc_pkg::DCC_SEL_CONTROL) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      feedback <= dcc_pkg::DCC_MASK_RESET;
    end else if (i_wr && sel == dcc_pkg::DCC_SEL_MASK) begin
      feedback <= dcc_alias(alias_op, feedback, i_wdata);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= dcc_pkg::DCC_SEED_RESET;
    end else if (seed_wr) begin
      if (ip_mode) begin
        state <= {16'h0000, ~next_seed[15:0]};
      end else begin
        state <= next_seed & len_mask;
      end
    end else if (i_xfer_valid && engaged) begin
      state <= step.next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (sel)
        dcc_pkg::DCC_SEL_CONTROL: o_rdata <= ctrl;
        dcc_pkg::DCC_SEL_SEED: o_rdata <= rd_value;
        dcc_pkg::DCC_SEL_MASK: o_rdata <= feedback;
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Destination data path.
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_dst_write <= 1'b0;
      o_dst_data <= 32'h0000_0000;
      o_dst_to_start <= 1'b0;
    end else if (i_block_done && engaged && append) begin
      o_dst_write <= 1'b1;
      o_dst_data <= rd_value;
      o_dst_to_start <= 1'b1;
    end else if (i_xfer_valid) begin
      o_dst_write <= !(engaged && append);
      o_dst_data <= (engaged && write_reorder) ? reordered : i_xfer_data;
      o_dst_to_start <= 1'b0;
    end else begin
      o_dst_write <= 1'b0;
      o_dst_to_start <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  sequence s_seed_write_full;
    i_wr && sel == dcc_pkg::DCC_SEL_SEED && alias_op == dcc_pkg::DCC_ALIAS_WRITE && !ip_mode
      && ctrl[dcc_pkg::DCC_BIT_POLY_LENGTH_MINUS_ONE +: 5] == 5'd31;
  endsequence

  sequence s_seed_read_quiet;
    i_rd && sel == dcc_pkg::DCC_SEL_SEED && !(i_xfer_valid && engaged) && !i_wr;
  endsequence

  sequence s_append_done;
    i_block_done && engaged && append;
  endsequence

  property p_seed_roundtrip;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_seed_write_full ##1 s_seed_read_quiet |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_seed_roundtrip: assert property (p_seed_roundtrip) else $error("seed not read back");

  property p_append_result;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_append_done |=> o_dst_write && o_dst_to_start && o_dst_data == $past(rd_value);
  endproperty
  a_append_result: assert property (p_append_result) else $error("result not appended");

  property p_append_swallow;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && engaged && append && !i_block_done |=> !o_dst_write;
  endproperty
  a_append_swallow: assert property (p_append_swallow) else $error("append leaked data");

  property p_pass_through;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && !engaged |=> o_dst_write && o_dst_data == $past(i_xfer_data);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("bypass data altered");

  property p_unaltered;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && engaged && !append && !write_reorder && !i_block_done
        |=> o_dst_write && o_dst_data == $past(i_xfer_data);
  endproperty
  a_unaltered: assert property (p_unaltered) else $error("data altered");

  property p_word_reverse;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && engaged && !append && write_reorder
        && ctrl[dcc_pkg::DCC_BIT_BYTE_ORDER +: 2] == dcc_pkg::DCC_BYTE_ORDER_SELECT_WORD_REV
        |=> o_dst_data == {$past(i_xfer_data[7:0]), $past(i_xfer_data[15:8]),
                           $past(i_xfer_data[23:16]), $past(i_xfer_data[31:24])};
  endproperty
  a_word_reverse: assert property (p_word_reverse) else $error("bytes not reversed");

  property p_no_append_with_reorder;
    @(posedge i_clk) disable iff (i_sys_rst)
      ctrl[dcc_pkg::DCC_BIT_WRITE_REORDER] |-> !ctrl[dcc_pkg::DCC_BIT_APPEND];
  endproperty
  a_no_append_with_reorder: assert property (p_no_append_with_reorder)
    else $error("append set with reorder");

  property p_control_reserved;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_rd && sel == dcc_pkg::DCC_SEL_CONTROL |=> (o_rdata & ~dcc_pkg::DCC_CONTROL_WMASK) == 0;
  endproperty
  a_control_reserved: assert property (p_control_reserved) else $error("reserved bit set");

  property p_ip_upper_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_rd && sel == dcc_pkg::DCC_SEL_SEED && ip_mode |=> o_rdata[31:16] == 16'h0000;
  endproperty
  a_ip_upper_zero: assert property (p_ip_upper_zero) else $error("checksum upper bits");

  property p_length_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_rd && sel == dcc_pkg::DCC_SEL_SEED && !ip_mode |=> (o_rdata & ~$past(len_mask)) == 0;
  endproperty
  a_length_zero: assert property (p_length_zero) else $error("bits above length");

  property p_idle_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      !ctrl[dcc_pkg::DCC_BIT_ENABLE] && !seed_wr |=> $stable(state);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved while off");

  property p_half_swap;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && engaged && !append && write_reorder
        && ctrl[dcc_pkg::DCC_BIT_BYTE_ORDER +: 2] == dcc_pkg::DCC_BYTE_ORDER_SELECT_HALF_SWAP
        |=> o_dst_data == {$past(i_xfer_data[15:0]), $past(i_xfer_data[31:16])};
  endproperty
  a_half_swap: assert property (p_half_swap) else $error("halves not swapped");

  property p_half_reverse;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && engaged && !append && write_reorder
        && ctrl[dcc_pkg::DCC_BIT_BYTE_ORDER +: 2] == dcc_pkg::DCC_BYTE_ORDER_SELECT_HALF_REV
        |=> o_dst_data == {$past(i_xfer_data[23:16]), $past(i_xfer_data[31:24]),
                           $past(i_xfer_data[7:0]), $past(i_xfer_data[15:8])};
  endproperty
  a_half_reverse: assert property (p_half_reverse) else $error("halves not reversed");

  property p_ip_seed;
    @(posedge i_clk) disable iff (i_sys_rst)
      seed_wr && alias_op == dcc_pkg::DCC_ALIAS_WRITE && ip_mode
        |=> rd_value == {16'h0000, $past(i_wdata[15:0])};
  endproperty
  a_ip_seed: assert property (p_ip_seed) else $error("checksum seed not converted");

  property p_seed_mask;
    @(posedge i_clk) disable iff (i_sys_rst)
      seed_wr && alias_op == dcc_pkg::DCC_ALIAS_WRITE && !ip_mode
        |=> rd_value == ($past(i_wdata) & $past(len_mask));
  endproperty
  a_seed_mask: assert property (p_seed_mask) else $error("seed unmasked");

  property p_dst_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      !i_xfer_valid && !i_block_done |=> !o_dst_write && !o_dst_to_start;
  endproperty
  a_dst_quiet: assert property (p_dst_quiet) else $error("spurious destination write");

  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_sys_rst)
      !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data held");

  property p_bypass_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && !engaged && !seed_wr |=> $stable(state);
  endproperty
  a_bypass_hold: assert property (p_bypass_hold) else $error("bypass moved state");

  property p_other_channel;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_xfer_valid && ctrl[dcc_pkg::DCC_BIT_ENABLE]
        && i_xfer_chan != ctrl[dcc_pkg::DCC_BIT_CHANNEL +: 3]
        |=> o_dst_write && o_dst_data == $past(i_xfer_data);
  endproperty
  a_other_channel: assert property (p_other_channel) else $error("channel misrouted");
endmodule // dcc_crc_engine
`default_nettype wire

// [test/dcc_dma_model.sv]
// Behavioural DMA channel transfer side that feeds elements and takes destination writes.
`timescale 1ns/1ps
`default_nettype none
module dcc_dma_model (
  input wire logic i_clk,
  output logic o_xfer_valid,
  output logic [2:0] o_xfer_chan,
  output logic [1:0] o_xfer_size,
  output logic [31:0] o_xfer_data,
  output logic o_block_done,
  input wire logic i_dst_write,
  input wire logic [31:0] i_dst_data,
  input wire logic i_dst_to_start
);
  int n_dst = 0;
  logic [31:0] last_data = 32'h0;
  logic last_start = 1'b0;

  initial begin
    o_xfer_valid = 1'b0;
    o_xfer_chan = 3'h0;
    o_xfer_size = 2'h0;
    o_xfer_data = 32'h0;
    o_block_done = 1'b0;
  end

  // Moves one aligned element or ends a block; released data lines carry the inverse.
  task automatic send(input logic [2:0] ch, input logic [1:0] sz, input logic [31:0] d,
                      input logic done);
    @(posedge i_clk);
    o_xfer_valid <= ~done;
    o_block_done <= done;
    o_xfer_chan <= ch;
    o_xfer_size <= sz;
    o_xfer_data <= d;
    @(posedge i_clk);
    o_xfer_valid <= 1'b0;
    o_block_done <= 1'b0;
    o_xfer_data <= ~d;
  endtask

  // Records every destination write.
  always @(posedge i_clk) begin
    if (i_dst_write) begin
      n_dst <= n_dst + 1;
      last_data <= i_dst_data;
      last_start <= i_dst_to_start;
    end
  end
endmodule // dcc_dma_model
`default_nettype wire

// [test/dma_crc_checksum_engine_test.sv]
// Self-checking testbench of the DMA CRC and checksum engine.
`timescale 1ns/1ps
`default_nettype none
module dma_crc_checksum_engine_test;
  logic i_clk, i_sys_rst, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  wire logic xv, bd, dw, ds;
  wire logic [2:0] xc;
  wire logic [1:0] xs;
  wire logic [31:0] xd, dd, rdata;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  logic [31:0] e;
  logic [15:0] s;
  typedef struct {logic [31:0] ctl; logic [2:0] ch; logic [31:0] exp;} dcc_row_t;
  dcc_row_t rows[9] = '{
    '{32'h0000_0080, 3'h0, 32'h1122_3344}, '{32'h0800_0080, 3'h0, 32'h1122_3344},
    '{32'h1800_0080, 3'h0, 32'h4433_2211}, '{32'h2800_0080, 3'h0, 32'h3344_1122},
    '{32'h3800_0080, 3'h0, 32'h2211_4433}, '{32'h3000_0080, 3'h0, 32'h1122_3344},
    '{32'h1800_0003, 3'h3, 32'h1122_3344}, '{32'h1800_0083, 3'h2, 32'h1122_3344},
    '{32'h1800_0087, 3'h7, 32'h4433_2211}};

  dcc_crc_engine dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_xfer_valid(xv),
    .i_xfer_chan(xc), .i_xfer_size(xs), .i_xfer_data(xd), .i_block_done(bd),
    .o_dst_write(dw), .o_dst_data(dd), .o_dst_to_start(ds));
  dcc_dma_model dma_u (.i_clk(i_clk), .o_xfer_valid(xv), .o_xfer_chan(xc),
    .o_xfer_size(xs), .o_xfer_data(xd), .o_block_done(bd), .i_dst_write(dw),
    .i_dst_data(dd), .i_dst_to_start(ds));

  // ----------------------------------------
  // Reference models and bus tasks.
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] st, input logic [31:0] d,
      input int nb, input logic [4:0] pl, input logic [31:0] m, input logic rf);
    logic fb;
    for (int i = 0; i < 8 * nb; i++) begin
      fb = (rf ? st[0] : st[pl]) ^ (rf ? d[i] : d[(i / 8) * 8 + 7 - i % 8]);
      st = rf ? (st >> 1) : (st << 1);
      if (fb) st = st ^ m;
      st = st & (32'hFFFF_FFFF >> (5'd31 - pl));
    end
    return st;
  endfunction

  function automatic logic [15:0] csum(input logic [15:0] sm, input logic [31:0] d,
      input logic rf);
    logic [16:0] t;
    logic [15:0] u;
    for (int k = 0; k < 2; k++) begin
      u = d[16 * k +: 16];
      if (rf) u = {<<{u}};
      t = {1'b0, sm} + {1'b0, u};
      sm = t[15:0] + {15'h0, t[16]};
    end
    return sm;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask

  task automatic settle;
    @(posedge i_clk);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    #125000;
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence.
  // ----------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdchk(8'h00, 32'h0, "ctl reset");
    rdchk(8'h10, 32'h0, "seed reset");
    rdchk(8'h20, 32'h0, "mask reset");
    rdchk(8'h34, 32'h0, "unmapped");
    $display("reset test done");
    foreach (rows[r]) begin
      wr(8'h00, rows[r].ctl);
      n = dma_u.n_dst;
      dma_u.send(rows[r].ch, 2'h2, 32'h1122_3344, 1'b0);
      settle();
      chk(dma_u.n_dst, n + 1, "dst count");
      chk(dma_u.last_data, rows[r].exp, "dst data");
      chk({31'h0, dma_u.last_start}, 32'h0, "start flag");
    end
    $display("reorder table done");
    wr(8'h00, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h3900_1FA7, "ctl write");
    wr(8'h04, 32'h3000_0000);
    rdchk(8'h00, 32'h0900_1FA7, "ctl clear");
    wr(8'h08, 32'h3000_0018);
    rdchk(8'h00, 32'h3900_1FA7, "ctl set");
    wr(8'h0C, 32'h0000_00FF);
    rdchk(8'h00, 32'h3900_1F00, "ctl invert");
    wr(8'h20, 32'h0F0F_0000);
    wr(8'h2C, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'hF0F0_FFFF, "mask invert");
    wr(8'h24, 32'hF000_0000);
    wr(8'h28, 32'h0F00_0000);
    rdchk(8'h20, 32'h0FF0_FFFF, "mask clear set");
    $display("alias test done");
    for (int rf = 0; rf < 2; rf++) begin
      wr(8'h00, rf ? 32'h0100_0F81 : 32'h0000_0F81);
      wr(8'h20, rf ? 32'h0000_8408 : 32'h0000_1021);
      wr(8'h10, 32'hFFFF_FFFF);
      rdchk(8'h10, 32'h0000_FFFF, "seed length");
      dma_u.send(3'h1, 2'h2, 32'h3433_3231, 1'b0);
      dma_u.send(3'h1, 2'h0, 32'hAAAA_AA35, 1'b0);
      dma_u.send(3'h1, 2'h1, 32'h5555_3736, 1'b0);
      e = lfsr(32'h0000_FFFF, 32'h3433_3231, 4, 5'd15, rf ? 32'h8408 : 32'h1021, rf[0]);
      e = lfsr(e, 32'h0000_0035, 1, 5'd15, rf ? 32'h8408 : 32'h1021, rf[0]);
      e = lfsr(e, 32'h0000_3736, 2, 5'd15, rf ? 32'h8408 : 32'h1021, rf[0]);
      rdchk(8'h10, e, "lfsr result");
      wr(8'h00, rf ? 32'h0100_1FA2 : 32'h0000_1FA2);
      wr(8'h10, 32'hFFFF_1234);
      rdchk(8'h10, 32'h0000_1234, "csum seed");
      dma_u.send(3'h2, 2'h2, 32'h4500_0073, 1'b0);
      dma_u.send(3'h2, 2'h3, 32'h0000_4000, 1'b0);
      s = csum(csum(16'hEDCB, 32'h4500_0073, rf[0]), 32'h0000_4000, rf[0]);
      rdchk(8'h10, {16'h0, ~s}, "csum result");
    end
    $display("crc test done");
    wr(8'h00, 32'h0000_07C0);
    wr(8'h20, 32'h0000_0007);
    wr(8'h10, 32'h0);
    n = dma_u.n_dst;
    dma_u.send(3'h0, 2'h2, 32'h1234_5678, 1'b0);
    dma_u.send(3'h0, 2'h0, 32'h0000_00AB, 1'b0);
    settle();
    chk(dma_u.n_dst, n, "append swallows");
    dma_u.send(3'h0, 2'h0, 32'h0, 1'b1);
    settle();
    e = lfsr(lfsr(32'h0, 32'h1234_5678, 4, 5'd7, 32'h7, 1'b0), 32'hAB, 1, 5'd7, 32'h7, 1'b0);
    chk(dma_u.n_dst, n + 1, "append write");
    chk({31'h0, dma_u.last_start}, 32'h1, "append start");
    chk(dma_u.last_data, e, "append data");
    $display("append test done");
    wr(8'h00, 32'h0000_1F00);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= 8'h10;
    i_wdata <= 32'hCAFE_0123;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, 32'hCAFE_0123, "seed walk");
    wr(8'h18, 32'h0000_F000);
    rdchk(8'h10, 32'hCAFE_F123, "seed set");
    wr(8'h00, 32'h0000_00A0);
    wr(8'h10, 32'hFFFF_0000);
    dma_u.send(3'h0, 2'h0, 32'hABCD_EF12, 1'b0);
    rdchk(8'h10, 32'h0000_FFED, "csum byte");
    $display("awkward test done");
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdchk(8'h00, 32'h0, "ctl rereset");
    rdchk(8'h20, 32'h0, "mask rereset");
    $display("second reset test done");
    end_sim();
  end
endmodule // dma_crc_checksum_engine_test
`default_nettype wire
